// *** rtl/lrs_ctrl.sv ***
// register bank and state decode for the panel and internal logic ldo rails
// assumes reg_* port is synchronous to sys_clk, one access per strobe
// Operation
// - state codes: 4 off, 5 low, 6/7 active
// - exit codes same; 0-3 mean do not copy
// - standby exit copies exit field to state
// - panel register at 0x46, reset 0x24
// - internal register at 0x41, reset 0x07
// - discharge each rail while shut down or in a reserved code
// - each rail register controlled independently
// - report over-current and under-voltage per rail
module lrs_ctrl (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic       standby_exit_pin,
    output logic      [1:0] panel_ldo_mode,
    output logic      [1:0] internal_logic_ldo_mode,
    output logic            panel_ldo_discharge,
    output logic            internal_logic_ldo_discharge,
    input  wire logic       panel_ldo_oc_sense,
    input  wire logic       panel_ldo_uv_sense,
    input  wire logic       internal_logic_ldo_oc_sense,
    input  wire logic       internal_logic_ldo_uv_sense,
    output logic            panel_ldo_over_current,
    output logic            panel_ldo_under_voltage,
    output logic            internal_logic_ldo_over_current,
    output logic            internal_logic_ldo_under_voltage
);
    // rail index of each register slice
    localparam int RAILS = 2;
    localparam int PANEL = 0;
    localparam int INTL  = 1;

    // per-rail state: index 0 panel rail, index 1 internal logic rail
    logic [7:0]         ctrl_ff  [RAILS];
    logic [7:0]         nxt_ctrl [RAILS];
    lrs_pkg::lrs_rail_t mode     [RAILS];
    logic               wr_sel   [RAILS];
    logic               oc_sense [RAILS];
    logic               uv_sense [RAILS];
    logic               oc_ff    [RAILS];
    logic               nxt_oc   [RAILS];
    logic               uv_ff    [RAILS];
    logic               nxt_uv   [RAILS];

    // read port
    logic [7:0]         rdata_ff;
    logic [7:0]         nxt_rdata;
    logic               rvalid_ff;
    logic               nxt_rvalid;

    // standby exit edge detect
    logic               exit_d_ff;
    logic               nxt_exit_d;
    logic               exit_rise;

    // register address of a rail
    function automatic logic [7:0] lrs_rail_addr(input int idx);
        if (idx == PANEL) begin
            return lrs_pkg::PANEL_CTRL_ADDR;
        end else begin
            return lrs_pkg::INTERNAL_CTRL_ADDR;
        end
    endfunction : lrs_rail_addr

    // power-on contents of a rail register
    function automatic logic [7:0] lrs_rail_reset(input int idx);
        if (idx == PANEL) begin
            return lrs_pkg::PANEL_CTRL_RESET;
        end else begin
            return lrs_pkg::INTERNAL_CTRL_RESET;
        end
    endfunction : lrs_rail_reset

    // code to rail mode; reserved codes 0-3 all reported as LRS_RAIL_RSVD
    function automatic lrs_pkg::lrs_rail_t lrs_decode(input logic [2:0] code);
        if (code == lrs_pkg::CODE_OFF) begin
            return lrs_pkg::LRS_RAIL_OFF;
        end else if (code == lrs_pkg::CODE_LOW_POWER) begin
            return lrs_pkg::LRS_RAIL_LOW;
        end else if (code[2]) begin
            return lrs_pkg::LRS_RAIL_ACTIVE;
        end
        return lrs_pkg::LRS_RAIL_RSVD;
    endfunction : lrs_decode

    // reserved codes count as shut down so the rail is never left floating
    function automatic logic lrs_discharge(input lrs_pkg::lrs_rail_t m);
        return (m == lrs_pkg::LRS_RAIL_OFF)
            || (m == lrs_pkg::LRS_RAIL_RSVD);
    endfunction : lrs_discharge

    // flags are only meaningful while the rail is powered
    function automatic logic lrs_powered(input lrs_pkg::lrs_rail_t m);
        return m != lrs_pkg::LRS_RAIL_OFF;
    endfunction : lrs_powered

    // apply write then standby exit; exit copy wins its own field only
    function automatic logic [7:0] lrs_next(input logic [7:0] cur,
                                            input logic [7:0] wdata,
                                            input logic       sel,
                                            input logic       ext);
        logic [7:0] v;
        v = cur;
        // bits 7:6 never stored, so reads return zero there
        if (sel) begin
            v = wdata & lrs_pkg::WRITABLE_MASK;
        end
        // only codes 4..7 are copied; 0..3 keep the state field
        if (ext && v[lrs_pkg::EXIT_LSB+2]) begin
            v[lrs_pkg::STATE_LSB +: 3] = v[lrs_pkg::EXIT_LSB +: 3];
        end
        return v;
    endfunction : lrs_next

    // sense inputs gathered by rail index
    assign oc_sense[PANEL] = panel_ldo_oc_sense;
    assign uv_sense[PANEL] = panel_ldo_uv_sense;
    assign oc_sense[INTL]  = internal_logic_ldo_oc_sense;
    assign uv_sense[INTL]  = internal_logic_ldo_uv_sense;

    // one register, decode and monitor slice per rail
    genvar r;
    generate
        for (r = 0; r < RAILS; r++) begin : g_rail
            assign wr_sel[r] = reg_wr && (reg_addr == lrs_rail_addr(r));

            // a write in the exit cycle lands first, then the copy is taken from it
            always_comb begin
                nxt_ctrl[r] = lrs_next(ctrl_ff[r], reg_wdata, wr_sel[r], exit_rise);
                nxt_oc[r]   = oc_sense[r] & lrs_powered(mode[r]);
                nxt_uv[r]   = uv_sense[r] & lrs_powered(mode[r]);
            end

            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    ctrl_ff[r] <= lrs_rail_reset(r);
                    oc_ff[r]   <= 1'b0;
                    uv_ff[r]   <= 1'b0;
                end else begin
                    ctrl_ff[r] <= nxt_ctrl[r];
                    oc_ff[r]   <= nxt_oc[r];
                    uv_ff[r]   <= nxt_uv[r];
                end
            end

            assign mode[r] = lrs_decode(ctrl_ff[r][lrs_pkg::STATE_LSB +: 3]);
        end
    endgenerate

    // read group: registered, one cycle after the strobe
    always_comb begin
        // rvalid follows every strobe, mapped or not
        nxt_rvalid = reg_rd;
        nxt_rdata  = 8'h00;
        if (reg_rd) begin
            // unmapped and idle cycles read as zero
            unique case (reg_addr)
                lrs_pkg::PANEL_CTRL_ADDR:    nxt_rdata = ctrl_ff[PANEL];
                lrs_pkg::INTERNAL_CTRL_ADDR: nxt_rdata = ctrl_ff[INTL];
                default:                     nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // exit group; pin taken as synchronous, a slow pin needs a synchroniser outside
    always_comb begin
        nxt_exit_d = standby_exit_pin;
    end

    // reset to the idle low level so release gives no false edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            exit_d_ff <= 1'b0;
        end else begin
            exit_d_ff <= nxt_exit_d;
        end
    end

    // a level held high copies once only
    assign exit_rise = standby_exit_pin & ~exit_d_ff;

    // read port outputs
    assign reg_rdata  = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // decoded rail state
    assign panel_ldo_mode               = mode[PANEL];
    assign internal_logic_ldo_mode      = mode[INTL];
    assign panel_ldo_discharge          = lrs_discharge(mode[PANEL]);
    assign internal_logic_ldo_discharge = lrs_discharge(mode[INTL]);

    // monitor flags, non-sticky levels
    assign panel_ldo_over_current           = oc_ff[PANEL];
    assign panel_ldo_under_voltage          = uv_ff[PANEL];
    assign internal_logic_ldo_over_current  = oc_ff[INTL];
    assign internal_logic_ldo_under_voltage = uv_ff[INTL];
endmodule : lrs_ctrl

// *** rtl/lrs_pkg.sv ***
// constants for the two-rail ldo state control register bank
// assumes an 8-bit register port driven by the host spi front end
package lrs_pkg;
    localparam logic [7:0] INTERNAL_CTRL_ADDR  = 8'h41;
    localparam logic [7:0] PANEL_CTRL_ADDR     = 8'h46;
    localparam logic [7:0] INTERNAL_CTRL_RESET = 8'h07;
    localparam logic [7:0] PANEL_CTRL_RESET    = 8'h24;
    localparam int         STATE_LSB           = 0;
    localparam int         EXIT_LSB            = 3;
    localparam logic [7:0] WRITABLE_MASK       = 8'h3f;
    localparam logic [2:0] CODE_OFF            = 3'h4;
    localparam logic [2:0] CODE_LOW_POWER      = 3'h5;

    typedef enum logic [1:0] {
        LRS_RAIL_OFF    = 2'h0,
        LRS_RAIL_LOW    = 2'h1,
        LRS_RAIL_ACTIVE = 2'h3,
        LRS_RAIL_RSVD   = 2'h2
    } lrs_rail_t;
endpackage : lrs_pkg

// *** test/lrs_ctrl_sva.sv ***
// port checks for the two-rail ldo state bank
// assumes one clock domain, bound from the bench top
module lrs_chk (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       standby_exit_pin,
    input wire logic [1:0] panel_ldo_mode,
    input wire logic [1:0] internal_logic_ldo_mode,
    input wire logic       internal_logic_ldo_discharge
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_panel_reset: assert property ($rose(rst_n) |-> panel_ldo_mode == 2'h0)
        else $error("panel rail not off after reset");
    chk_int_reset: assert property (
        $rose(rst_n) |-> internal_logic_ldo_mode == 2'h3)
        else $error("internal rail not active after reset");
    chk_int_discharge: assert property (
        internal_logic_ldo_discharge == !internal_logic_ldo_mode[0])
        else $error("discharge wrong for mode");
    chk_rail_indep: assert property (
        reg_wr && reg_addr == 8'h41 && !standby_exit_pin |=> $stable(panel_ldo_mode))
        else $error("panel mode moved on internal write");
    chk_int_hold: assert property (
        !reg_wr && !standby_exit_pin |=> $stable(internal_logic_ldo_mode))
        else $error("internal mode moved without cause");
    chk_read_valid: assert property (reg_rvalid == $past(reg_rd && rst_n))
        else $error("read valid misplaced");
    chk_rsvd_zero: assert property (reg_rvalid |-> reg_rdata[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
    chk_unmapped_zero: assert property (
        reg_rd && !(reg_addr inside {8'h41, 8'h46}) |=> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
endmodule : lrs_chk

// *** test/lrs_host.sv ***
// host spi controller model: single-byte register accesses
// assumes read data lands one cycle after the strobe edge
module lrs_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        // released data flips so stale bytes never look valid
        @(posedge sys_clk) {reg_wr, reg_wdata} <= {1'b0, ~d};
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : lrs_host

// *** test/test_lrs_ctrl.sv ***
// self-checking bench for the two-rail ldo state bank
// assumes lrs_host owns the register port
module test_lrs_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk, rst_n, standby_exit_pin;
    logic [3:0] sen;
    logic [7:0] d;
    int         errors, checked;
    wire        reg_wr, reg_rd, reg_rvalid, panel_ldo_discharge, internal_logic_ldo_discharge;
    wire        panel_ldo_over_current, panel_ldo_under_voltage;
    wire        internal_logic_ldo_over_current, internal_logic_ldo_under_voltage;
    wire  [7:0] reg_addr, reg_wdata, reg_rdata;
    wire  [1:0] panel_ldo_mode, internal_logic_ldo_mode;
    lrs_host u_lrs_host (.*);
    lrs_ctrl u_lrs_ctrl (.*, .panel_ldo_oc_sense(sen[3]), .panel_ldo_uv_sense(sen[2]),
        .internal_logic_ldo_oc_sense(sen[1]), .internal_logic_ldo_uv_sense(sen[0]));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task cmp(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task t_reset;
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        u_lrs_host.rd(8'h46, d);
        cmp(d, 8'h24);
        u_lrs_host.rd(8'h41, d);
        cmp(d, 8'h07);
        u_lrs_host.rd(8'h43, d);
        cmp(d, 8'h00);
        cmp({6'h00, panel_ldo_discharge, internal_logic_ldo_discharge}, 8'h02);
        $display("reset defaults done");
    endtask : t_reset
    task t_codes;
        for (int i = 0; i < 8; i++) begin
            u_lrs_host.wr(8'h41, 8'hc0 | i[7:0]);
            #1 cmp({internal_logic_ldo_mode, panel_ldo_mode},
                   {i[2] ? {i[1], i[1] | i[0]} : 2'h2, 2'h0});
        end
        u_lrs_host.rd(8'h41, d);
        cmp(d, 8'h07);
        $display("state codes done");
    endtask : t_codes
    task t_exit;
        u_lrs_host.wr(8'h46, 8'h2c);
        u_lrs_host.wr(8'h41, 8'h17);
        @(posedge sys_clk) standby_exit_pin <= 1'b1;
        @(posedge sys_clk) sen <= 4'hf;
        @(posedge sys_clk) standby_exit_pin <= 1'b0;
        #1 cmp({2'h0, panel_ldo_over_current, internal_logic_ldo_under_voltage,
            internal_logic_ldo_mode, panel_ldo_mode}, 8'h3d);
        u_lrs_host.rd(8'h46, d);
        cmp(d, 8'h2d);
        $display("standby exit done");
    endtask : t_exit
    task t_flags;
        @(posedge sys_clk) sen <= 4'h5;
        @(posedge sys_clk);
        #1 cmp({4'h0, panel_ldo_over_current, panel_ldo_under_voltage,
            internal_logic_ldo_over_current, internal_logic_ldo_under_voltage}, 8'h05);
        u_lrs_host.wr(8'h46, 8'h24);
        @(posedge sys_clk);
        #1 cmp({4'h0, panel_ldo_over_current, panel_ldo_under_voltage,
            internal_logic_ldo_over_current, internal_logic_ldo_under_voltage}, 8'h01);
        cmp({6'h00, panel_ldo_discharge, internal_logic_ldo_discharge}, 8'h02);
        u_lrs_host.wr(8'h41, 8'h04);
        @(posedge sys_clk);
        #1 cmp({4'h0, panel_ldo_over_current, panel_ldo_under_voltage,
            internal_logic_ldo_over_current, internal_logic_ldo_under_voltage}, 8'h00);
        cmp({6'h00, panel_ldo_discharge, internal_logic_ldo_discharge}, 8'h03);
        $display("monitor flags done");
    endtask : t_flags
    initial begin
        {rst_n, standby_exit_pin} = 2'h0;
        sen = 4'h0;
        t_reset;
        t_codes;
        t_exit;
        t_flags;
        t_reset;
        summarize;
    end
endmodule : test_lrs_ctrl
bind lrs_ctrl lrs_chk u_lrs_chk (.*);
